// [core/fspc_pkg.sv]
// Package for the flash self-program controller: sizes, field positions, timing counts, carriers.
// Assumes a single 40 MHz system clock.
package fspc_pkg;
   // ==================================================================
   // Array geometry
   localparam int unsigned MAIN_BYTES    = 65536;
   localparam int unsigned SCRATCH_BYTES = 128;
   localparam int unsigned PAGE_BYTES    = 512;
   localparam int unsigned ADDR_W        = 16;
   localparam int unsigned PAGE_OFF_W    = 9;
   localparam int unsigned SCRATCH_OFF_W = 7;
   localparam logic [7:0]  ERASED_BYTE   = 8'hFF;
   // ==================================================================
   // Control bit positions
   localparam int unsigned PSC_REDIRECT_BIT = 0;
   localparam int unsigned PSC_ERASE_BIT    = 1;
   localparam int unsigned PSC_SCRATCH_BIT  = 2;
   localparam int unsigned FSC_UNLOCK_BIT   = 0;
   localparam logic [7:0]  PSC_RESET        = 8'h00;
   localparam logic [7:0]  FSC_RESET        = 8'h00;
   // ==================================================================
   // Timing
   localparam int unsigned CLK_HZ        = 40000000;
   localparam int unsigned WRITE_TIME_US = 40;
   localparam int unsigned ERASE_TIME_MS = 10;
   localparam int unsigned WRITE_CYCLES  = (WRITE_TIME_US * (CLK_HZ / 1000000));
   localparam int unsigned ERASE_CYCLES  = (ERASE_TIME_MS * (CLK_HZ / 1000));
   localparam int unsigned TIMER_W       = 20;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [7:0]        data;
   } fspc_req_t;

   typedef enum logic [3:0] {
      FSPC_IDLE   = 4'b0001,
      FSPC_WRITE  = 4'b0010,
      FSPC_ERASE  = 4'b0100,
      FSPC_FINISH = 4'b1000
   } fspc_state_t;
endpackage

// [core/fspc_mem.sv]
// Byte-wide flash array model with registered read data and single-byte clear for erase.
// Assumes the controller serialises every modification.
`timescale 1ns/1ps
module fspc_mem
   import fspc_pkg::*;
#(
   parameter int unsigned DEPTH = 65536,
   parameter int unsigned AW    = 16
) (
   input  wire logic          sys_clk,
   input  wire logic          we,
   input  wire logic          clr,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [7:0]    wdata,
   input  wire logic [AW-1:0] raddr,
   output logic      [7:0]    rdata_ff
);
   logic [7:0] mem [DEPTH];

   // ==================================================================
   // Program ANDs in new data so bits only fall; erase rewrites erased value
   always_ff @(posedge sys_clk) begin
      if (clr) begin
         mem[waddr] <= ERASED_BYTE;
      end else if (we) begin
         mem[waddr] <= mem[waddr] & wdata;
      end
      rdata_ff <= mem[raddr];
   end
endmodule

// [core/fspc_ctrl.sv]
// Flash self-program controller: redirects data-space writes to flash, times program and erase,
// stalls the core meanwhile and holds off interrupt service.
// Assumes the core presents one write strobe per move write and honours stall the same cycle.
//
// Contract
// - 64 kB main flash plus 128-byte extra area, byte programmable.
// - Programming only clears bits; only erase sets them.
// - 512-byte pages; erase clears a whole page to 0xFF.
// - Write and erase timed internally; no polling needed.
// - Core stalled during operation; interrupts held, serviced afterwards.
// - Redirect bit 1 sends move writes to flash, 0 to external RAM.
// - Redirect bit stays set until software clears it.
// - Move reads always go to external RAM; flash read via code reads.
// - Software writes and erases need the unlock bit set.
// - Erase-enable plus redirect: a move write erases its page.
// - Erase-enable clear, redirect set: a move write programs the byte.
// - Blank device only programmable through the debug port; not enforced, unlocked move writes program it too.
// - Scratchpad select maps accesses to 128-byte sector; no execution there.
`timescale 1ns/1ps
module fspc_ctrl
   import fspc_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              rst_n,
   // Control register writes from the core
   input  wire logic              psc_wr,
   input  wire logic [7:0]        psc_wdata,
   input  wire logic              fsc_wr,
   input  wire logic [7:0]        fsc_wdata,
   output logic      [7:0]        program_store_control,
   output logic      [7:0]        flash_scale_control,
   // Data-space move accesses
   input  wire logic              movx_wr,
   input  wire logic              movx_rd,
   input  wire fspc_req_t         movx_req,
   output logic                   external_data_ram_wr,
   output logic                   external_data_ram_rd,
   output fspc_req_t              external_data_ram_req,
   // Code-space reads
   input  wire logic              code_rd,
   input  wire logic              code_fetch,
   input  wire logic [ADDR_W-1:0] code_addr,
   output logic      [7:0]        code_rdata,
   output logic                   fetch_fault,
   // Debug-port programming path
   input  wire logic              dbg_wr,
   input  wire logic              dbg_erase,
   input  wire fspc_req_t         dbg_req,
   // Core handshake
   output logic                   cpu_stall,
   output logic                   irq_hold,
   output logic                   flash_busy
);
   // ==================================================================
   // Reset synchroniser
   logic rst_meta_ff;
   logic rst_sync_ff;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end

   // ==================================================================
   // Control registers
   logic [7:0] psc_ff;
   logic [7:0] fsc_ff;
   logic [7:0] nxt_psc;
   logic [7:0] nxt_fsc;

   always_comb begin
      nxt_psc = psc_ff;
      nxt_fsc = fsc_ff;
      // Only software writes change these; operations never touch them
      if (psc_wr) begin
         nxt_psc = psc_wdata;
      end
      if (fsc_wr) begin
         nxt_fsc = fsc_wdata;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         psc_ff <= PSC_RESET;
         fsc_ff <= FSC_RESET;
      end else begin
         psc_ff <= nxt_psc;
         fsc_ff <= nxt_fsc;
      end
   end

   assign program_store_control = psc_ff;
   assign flash_scale_control   = fsc_ff;

   logic redirect;
   logic erase_en;
   logic scratch_sel;
   logic unlocked;
   assign redirect    = psc_ff[PSC_REDIRECT_BIT];
   assign erase_en    = psc_ff[PSC_ERASE_BIT];
   assign scratch_sel = psc_ff[PSC_SCRATCH_BIT];
   assign unlocked    = fsc_ff[FSC_UNLOCK_BIT];

   // ==================================================================
   // Address mapping: scratch sector sits above the main array
   function automatic logic [ADDR_W:0] map_addr(input logic [ADDR_W-1:0] a, input logic scr);
      if (scr) begin
         map_addr = {1'b1, {(ADDR_W-SCRATCH_OFF_W){1'b0}}, a[SCRATCH_OFF_W-1:0]};
      end else begin
         map_addr = {1'b0, a};
      end
   endfunction

   // ==================================================================
   // Request steering
   logic flash_wr_req;
   logic sw_go;
   logic dbg_go;
   assign flash_wr_req = movx_wr && redirect;
   assign sw_go        = flash_wr_req && unlocked;
   assign dbg_go       = dbg_wr || dbg_erase;

   // Move reads never reach flash; non-redirected writes go out as RAM writes
   assign external_data_ram_rd  = movx_rd;
   assign external_data_ram_wr  = movx_wr && !redirect;
   assign external_data_ram_req = movx_req;

   // ==================================================================
   // Sequencer
   fspc_state_t        state_ff;
   fspc_state_t        nxt_state;
   logic [TIMER_W-1:0] timer_ff;
   logic [TIMER_W-1:0] nxt_timer;
   logic [ADDR_W:0]    op_addr_ff;
   logic [ADDR_W:0]    nxt_op_addr;
   logic [7:0]         op_data_ff;
   logic [7:0]         nxt_op_data;
   logic               op_scr_ff;
   logic               nxt_op_scr;
   logic [PAGE_OFF_W-1:0] wipe_ff;
   logic [PAGE_OFF_W-1:0] nxt_wipe;

   logic               start;
   logic               start_erase;
   fspc_req_t          start_req;
   logic               start_scr;

   always_comb begin
      start       = 1'b0;
      start_erase = 1'b0;
      start_req   = movx_req;
      start_scr   = scratch_sel;
      if (dbg_go) begin
         start       = 1'b1;
         start_erase = dbg_erase;
         start_req   = dbg_req;
         start_scr   = 1'b0;
      end else if (sw_go) begin
         start       = 1'b1;
         start_erase = erase_en;
      end
   end

   logic mem_we;
   logic mem_clr;
   logic [ADDR_W:0] mem_waddr;
   logic [PAGE_OFF_W-1:0] page_mask;
   assign page_mask = (op_scr_ff) ? PAGE_OFF_W'(SCRATCH_BYTES - 1) : PAGE_OFF_W'(PAGE_BYTES - 1);

   always_comb begin
      nxt_state   = state_ff;
      nxt_timer   = timer_ff;
      nxt_op_addr = op_addr_ff;
      nxt_op_data = op_data_ff;
      nxt_op_scr  = op_scr_ff;
      nxt_wipe    = wipe_ff;
      mem_we      = 1'b0;
      mem_clr     = 1'b0;
      mem_waddr   = op_addr_ff;
      case (state_ff)
         FSPC_IDLE: begin
            if (start) begin
               nxt_op_addr = map_addr(start_req.addr, start_scr);
               nxt_op_data = start_req.data;
               nxt_op_scr  = start_scr;
               nxt_wipe    = '0;
               if (start_erase) begin
                  nxt_state = FSPC_ERASE;
                  nxt_timer = TIMER_W'(ERASE_CYCLES - 1);
               end else begin
                  nxt_state = FSPC_WRITE;
                  nxt_timer = TIMER_W'(WRITE_CYCLES - 1);
               end
            end
         end
         FSPC_WRITE: begin
            if (timer_ff == '0) begin
               mem_we    = 1'b1;
               nxt_state = FSPC_FINISH;
            end else begin
               nxt_timer = timer_ff - 1'b1;
            end
         end
         FSPC_ERASE: begin
            // Page cleared one byte per cycle inside the long erase window
            if ((wipe_ff & page_mask) == wipe_ff) begin
               mem_clr   = 1'b1;
               mem_waddr = op_scr_ff
                  ? {op_addr_ff[ADDR_W:SCRATCH_OFF_W], wipe_ff[SCRATCH_OFF_W-1:0]}
                  : {op_addr_ff[ADDR_W:PAGE_OFF_W], wipe_ff};
            end
            if (wipe_ff != PAGE_OFF_W'(PAGE_BYTES - 1)) begin
               nxt_wipe = wipe_ff + 1'b1;
            end
            if (timer_ff == '0) begin
               nxt_state = FSPC_FINISH;
            end else begin
               nxt_timer = timer_ff - 1'b1;
            end
         end
         FSPC_FINISH: begin
            nxt_state = FSPC_IDLE;
         end
         default: begin
            nxt_state = FSPC_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         state_ff   <= FSPC_IDLE;
         timer_ff   <= '0;
         op_addr_ff <= '0;
         op_data_ff <= 8'h00;
         op_scr_ff  <= 1'b0;
         wipe_ff    <= '0;
      end else begin
         state_ff   <= nxt_state;
         timer_ff   <= nxt_timer;
         op_addr_ff <= nxt_op_addr;
         op_data_ff <= nxt_op_data;
         op_scr_ff  <= nxt_op_scr;
         wipe_ff    <= nxt_wipe;
      end
   end

   // ==================================================================
   // Core stall and interrupt hold; a locked write never stalls
   logic busy;
   assign busy        = (state_ff != FSPC_IDLE);
   assign cpu_stall   = busy || (start && (state_ff == FSPC_IDLE));
   assign irq_hold    = cpu_stall;
   assign flash_busy  = busy;
   assign fetch_fault = code_fetch && scratch_sel;

   // ==================================================================
   // Flash array
   fspc_mem #(
      .DEPTH (MAIN_BYTES + SCRATCH_BYTES * 2),
      .AW    (ADDR_W + 1)
   ) u_mem (
      .sys_clk  (sys_clk),
      .we       (mem_we),
      .clr      (mem_clr),
      .waddr    (mem_waddr),
      .wdata    (op_data_ff),
      .raddr    (map_addr(code_addr, scratch_sel && code_rd)),
      .rdata_ff (code_rdata)
   );
endmodule

// [verification/fspc_ctrl_assertions.sv]
// Checker for the flash self-program controller, bound to fspc_ctrl.
// Assumes the fspc_pkg timing counts and one system clock.
`timescale 1ns/1ps
module fspc_ctrl_assertions
   import fspc_pkg::*;
(
   input wire logic       sys_clk,
   input wire logic       rst_n,
   input wire logic       psc_wr,
   input wire logic [7:0] program_store_control,
   input wire logic [7:0] flash_scale_control,
   input wire logic       movx_wr,
   input wire logic       movx_rd,
   input wire fspc_req_t  movx_req,
   input wire logic       external_data_ram_wr,
   input wire logic       external_data_ram_rd,
   input wire fspc_req_t  external_data_ram_req,
   input wire logic       code_fetch,
   input wire logic       fetch_fault,
   input wire logic       dbg_wr,
   input wire logic       dbg_erase,
   input wire logic       cpu_stall,
   input wire logic       irq_hold,
   input wire logic       flash_busy
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // ==================================================
   // Stall length counter
   logic [19:0] cnt_ff;
   logic [19:0] nxt_cnt;
   always_comb nxt_cnt = cpu_stall ? cnt_ff + 20'h1 : 20'h0;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) cnt_ff <= 20'h0;
      else cnt_ff <= nxt_cnt;
   end
   // ==================================================
   // Properties
   sequence s_take;
      !flash_busy && movx_wr && program_store_control[0] && flash_scale_control[0];
   endsequence
   sequence s_erase;
      !flash_busy && movx_wr && program_store_control[1:0] == 2'h3 && flash_scale_control[0];
   endsequence
   property p_ram;
      movx_wr && !program_store_control[0] |-> external_data_ram_wr && external_data_ram_req == movx_req;
   endproperty
   a_ram: assert property (p_ram) else $error("move write missed RAM");
   property p_no_ram;
      movx_wr && program_store_control[0] |-> !external_data_ram_wr;
   endproperty
   a_no_ram: assert property (p_no_ram) else $error("redirected write hit RAM");
   property p_rd;
      movx_rd |-> external_data_ram_rd;
   endproperty
   a_rd: assert property (p_rd) else $error("move read not sent to RAM");
   property p_locked;
      !flash_busy && movx_wr && !flash_scale_control[0] && !dbg_wr && !dbg_erase |-> !cpu_stall ##1 !flash_busy;
   endproperty
   a_locked: assert property (p_locked) else $error("locked write started op");
   property p_take;
      s_take |-> cpu_stall ##1 flash_busy;
   endproperty
   a_take: assert property (p_take) else $error("unlocked write not taken");
   property p_irq;
      irq_hold == cpu_stall;
   endproperty
   a_irq: assert property (p_irq) else $error("irq hold differs from stall");
   property p_len;
      $fell(cpu_stall) |-> cnt_ff == 20'h00642 || cnt_ff == 20'h61A82;
   endproperty
   a_len: assert property (p_len) else $error("stall length wrong");
   property p_erase;
      s_erase |=> flash_busy[*8] ##292 cpu_stall;
   endproperty
   a_erase: assert property (p_erase) else $error("erase ended early");
   property p_hold;
      program_store_control[0] && !psc_wr |=> program_store_control[0];
   endproperty
   a_hold: assert property (p_hold) else $error("redirect bit cleared");
   property p_fetch;
      fetch_fault == (code_fetch && program_store_control[2]);
   endproperty
   a_fetch: assert property (p_fetch) else $error("fetch fault wrong");
   property p_dbg;
      !flash_busy && (dbg_wr || dbg_erase) |-> cpu_stall ##1 flash_busy;
   endproperty
   a_dbg: assert property (p_dbg) else $error("debug request not taken");
endmodule
bind fspc_ctrl fspc_ctrl_assertions u_chk (.sys_clk, .rst_n, .psc_wr, .program_store_control,
   .flash_scale_control, .movx_wr, .movx_rd, .movx_req, .external_data_ram_wr, .external_data_ram_rd, .external_data_ram_req, .code_fetch,
   .fetch_fault, .dbg_wr, .dbg_erase, .cpu_stall, .irq_hold, .flash_busy);

// [verification/fspc_core_model.sv]
// Processor core model issuing move and code accesses.
// Assumes calls start at a falling edge phase.
`timescale 1ns/1ps
module fspc_core_model
   import fspc_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic [7:0]        code_rdata,
   input  wire logic              fetch_fault,
   output logic                   movx_wr,
   output logic                   movx_rd,
   output fspc_req_t              movx_req,
   output logic                   code_rd,
   output logic                   code_fetch,
   output logic      [ADDR_W-1:0] code_addr
);
   initial begin
      movx_wr = 1'b0;
      movx_rd = 1'b0;
      movx_req = '0;
      code_rd = 1'b0;
      code_fetch = 1'b0;
      code_addr = '0;
   end
   // Interrupts never run here, so no stray writes
   // Callers keep clear of the reserved top page
   task automatic mwr(input logic [15:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      movx_wr = 1'b1;
      movx_req = '{addr: a, data: d};
      @(negedge sys_clk);
      movx_wr = 1'b0;
      movx_req = ~movx_req;
   endtask
   task automatic mrd(input logic [15:0] a);
      @(negedge sys_clk);
      movx_rd = 1'b1;
      movx_req.addr = a;
      @(negedge sys_clk);
      movx_rd = 1'b0;
   endtask
   task automatic crd(input logic [15:0] a, input logic f, output logic [7:0] d, output logic flt);
      @(negedge sys_clk);
      code_rd = !f;
      code_fetch = f;
      code_addr = a;
      @(negedge sys_clk);
      d = code_rdata;
      flt = fetch_fault;
      code_rd = 1'b0;
      code_fetch = 1'b0;
      code_addr = ~a;
   endtask
endmodule

// [verification/flash_self_program_ctrl_tb.sv]
// Self-checking bench for the flash self-program controller.
// Assumes fspc_core_model plays the core; erase is started, never waited out.
`timescale 1ns/1ps
module flash_self_program_ctrl_tb;
   import fspc_pkg::*;
   logic                  sys_clk = 1'b0;
   logic                  rst_n = 1'b0;
   logic                  psc_wr = 1'b0;
   logic                  fsc_wr = 1'b0;
   logic      [7:0]       psc_wdata = 8'h00;
   logic      [7:0]       fsc_wdata = 8'h00;
   logic      [7:0]       program_store_control, flash_scale_control, code_rdata, rd;
   logic                  movx_wr, movx_rd, code_rd, code_fetch, external_data_ram_wr, external_data_ram_rd, flt;
   logic                  fetch_fault, cpu_stall, irq_hold, flash_busy;
   logic      [ADDR_W-1:0] code_addr;
   fspc_req_t             movx_req, external_data_ram_req;
   logic                  dbg_wr = 1'b0;
   logic                  dbg_erase = 1'b0;
   fspc_req_t             dbg_req = '0;
   int                    fail_count = 0;
   int                    cmp_count = 0;
   always #12.5 sys_clk = ~sys_clk;
   fspc_ctrl u_dut (.sys_clk, .rst_n, .psc_wr, .psc_wdata, .fsc_wr, .fsc_wdata, .program_store_control,
      .flash_scale_control, .movx_wr, .movx_rd, .movx_req, .external_data_ram_wr, .external_data_ram_rd, .external_data_ram_req, .code_rd,
      .code_fetch, .code_addr, .code_rdata, .fetch_fault, .dbg_wr, .dbg_erase, .dbg_req,
      .cpu_stall, .irq_hold, .flash_busy);
   fspc_core_model u_core (.sys_clk, .code_rdata, .fetch_fault, .movx_wr, .movx_rd, .movx_req, .code_rd,
      .code_fetch, .code_addr);
   // ==================================================
   // Tasks
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic finish_test();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic wreg(input logic fsc, input logic [7:0] v);
      @(negedge sys_clk);
      psc_wr = !fsc;
      fsc_wr = fsc;
      psc_wdata = v;
      fsc_wdata = v;
      @(negedge sys_clk);
      psc_wr = 1'b0;
      fsc_wr = 1'b0;
   endtask
   // Counts stalled cycles; a bound hit is a hang unless it was expected
   task automatic xfer(input logic dbg, input logic [15:0] a, input logic [7:0] d, input logic ex, input int en,
                       input int lim);
      int n;
      n = 0;
      fork
         begin
            if (dbg) begin
               @(negedge sys_clk);
               dbg_wr = 1'b1;
               dbg_req = '{addr: a, data: d};
               @(negedge sys_clk);
               dbg_wr = 1'b0;
            end else begin
               u_core.mwr(a, d);
            end
         end
         begin
            @(negedge sys_clk);
            #1;
            chk("external_data_ram_wr", ex, external_data_ram_wr);
            chk("irq_hold", en != 0, irq_hold);
            if (!dbg) begin
               chk("external_data_ram_req", {a, d}, external_data_ram_req);
            end
            while (cpu_stall === 1'b1 && n < lim) begin
               n++;
               @(negedge sys_clk);
               #1;
            end
         end
      join
      chk("stall_cycles", en, n);
      if (n == lim && en != lim) begin
         fail_count++;
         finish_test();
      end
   endtask
   // ==================================================
   // Sequence
   initial begin
      repeat (4) @(negedge sys_clk);
      rst_n = 1'b1;
      repeat (3) @(negedge sys_clk);
      chk("psc_reset", 8'h00, program_store_control);
      xfer(1'b0, 16'h1234, 8'h00, 1'b1, 0, 10);
      wreg(1'b0, 8'h01);
      xfer(1'b0, 16'h1234, 8'h00, 1'b0, 0, 10);
      fork
         u_core.mrd(16'h0040);
         begin
            @(negedge sys_clk);
            #1;
            chk("external_data_ram_rd", 1'b1, external_data_ram_rd);
         end
      join
      wreg(1'b1, 8'h01);
      chk("unlock", 8'h01, flash_scale_control);
      xfer(1'b0, 16'h1234, 8'h00, 1'b0, WRITE_CYCLES + 2, 3000);
      u_core.crd(16'h1234, 1'b0, rd, flt);
      chk("flash_byte", 8'h00, rd);
      xfer(1'b0, 16'h1234, 8'hFF, 1'b0, WRITE_CYCLES + 2, 3000);
      u_core.crd(16'h1234, 1'b0, rd, flt);
      chk("flash_byte", 8'h00, rd);
      chk("redirect", 8'h01, program_store_control);
      // Erase outlasts the run; the page wipe is done long before the cut
      wreg(1'b0, 8'h03);
      xfer(1'b0, 16'h13FE, 8'h00, 1'b0, 2000, 2000);
      chk("flash_busy", 1'b1, flash_busy);
      u_core.crd(16'h1234, 1'b0, rd, flt);
      chk("erased_byte", ERASED_BYTE, rd);
      u_core.crd(16'h1200, 1'b0, rd, flt);
      chk("page_first", ERASED_BYTE, rd);
      u_core.crd(16'h13FF, 1'b0, rd, flt);
      chk("page_last", ERASED_BYTE, rd);
      @(negedge sys_clk);
      rst_n = 1'b0;
      repeat (4) @(negedge sys_clk);
      chk("stall_in_reset", 1'b0, cpu_stall);
      chk("psc_in_reset", 8'h00, program_store_control);
      chk("fsc_in_reset", 8'h00, flash_scale_control);
      rst_n = 1'b1;
      repeat (3) @(negedge sys_clk);
      xfer(1'b1, 16'h1234, 8'h5A, 1'b0, WRITE_CYCLES + 2, 3000);
      u_core.crd(16'h1234, 1'b0, rd, flt);
      chk("debug_byte", 8'h5A, rd);
      wreg(1'b1, 8'h01);
      wreg(1'b0, 8'h05);
      u_core.crd(16'h0010, 1'b1, rd, flt);
      chk("fetch_fault", 1'b1, flt);
      xfer(1'b0, 16'h1234, 8'h00, 1'b0, WRITE_CYCLES + 2, 3000);
      u_core.crd(16'h1234, 1'b0, rd, flt);
      chk("scratch_byte", 8'h00, rd);
      wreg(1'b0, 8'h01);
      u_core.crd(16'h1234, 1'b0, rd, flt);
      chk("main_byte", 8'h5A, rd);
      finish_test();
   end
endmodule
